// ==== design/apd_pkg.sv ====
// constants and carriers shared by the automatic powerdown control block
`default_nettype none
package apd_pkg;
   // ****************************************
   // floppy register offsets
   // ****************************************
   localparam logic [2:0] APD_OFS_STATUS_A = 3'h0;
   localparam logic [2:0] APD_OFS_STATUS_B = 3'h1;
   localparam logic [2:0] APD_OFS_DIG_OUT = 3'h2;
   localparam logic [2:0] APD_OFS_RATE_MAIN = 3'h4;
   localparam logic [2:0] APD_OFS_FIFO = 3'h5;
   localparam logic [2:0] APD_OFS_DIN_CFG = 3'h7;
   // ****************************************
   // field positions and values
   // ****************************************
   localparam int APD_DOR_MOTOR_LO = 4;
   localparam int APD_DOR_NRESET = 2;
   localparam int APD_DSR_SWRESET = 7;
   localparam int APD_CFG_FDC = 0;
   localparam int APD_CFG_PAR = 3;
   localparam int APD_CFG_SER0 = 4;
   localparam logic [7:0] APD_MSR_IDLE = 8'h80;
   localparam logic [7:0] APD_DOR_RST = 8'h04;
   localparam logic [7:0] APD_DSR_RST = 8'h02;
   localparam logic [7:0] APD_CCR_RST = 8'h02;
   // extended port control mode codes
   localparam logic [2:0] APD_ECR_SPP = 3'h0;
   localparam logic [2:0] APD_ECR_BYTE = 3'h1;
   localparam logic [2:0] APD_ECR_EPP = 3'h4;
   // ****************************************
   // timing
   // ****************************************
   localparam int APD_CLK_KHZ = 10000;
   localparam int APD_PD_TIME_MS = 10;
   localparam int APD_PD_CYCLES = APD_PD_TIME_MS * APD_CLK_KHZ;
   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [3:0] spindle_on;
      logic [3:0] drive_sel;
      logic write_stream;
      logic write_gate;
      logic head_dir;
      logic step;
      logic head_pick;
      logic density_pick;
      logic [1:0] rate_code_out;
   } apd_fdd_s;
   typedef enum logic [1:0] {
      APD_FDC_RUN = 2'b01,
      APD_FDC_SLEEP = 2'b10
   } apd_fdc_e;
endpackage : apd_pkg
`default_nettype wire

// ==== design/apd_serial_pd.sv ====
// automatic powerdown of one serial port transmitter and receiver
`default_nettype none
module apd_serial_pd
   import apd_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // control
   input wire logic enable,
   // uart state
   input wire logic thr_empty,
   input wire logic tsr_empty,
   input wire logic rx_fifo_empty,
   input wire logic rx_idle,
   input wire logic thr_write,
   input wire logic serial_in_line,
   input wire logic incoming_call_in,
   // powerdown flags and incoming call change flag
   output logic tx_pd,
   output logic rx_pd,
   output logic call_change
);
   logic tx_next, rx_next, line_reg, line_next, call_reg, call_next;
   logic change_next;

   always_comb begin
      line_next = serial_in_line;
      call_next = incoming_call_in;
      // stays live while asleep
      change_next = incoming_call_in != call_reg;
      tx_next = tx_pd;
      rx_next = rx_pd;
      if (!enable) begin
         tx_next = 1'b0;
         rx_next = 1'b0;
      end else begin
         if (thr_write) begin
            tx_next = 1'b0;
         end else if (thr_empty && tsr_empty) begin
            tx_next = 1'b1;
         end
         if (serial_in_line != line_reg) begin
            rx_next = 1'b0;
         end else if (rx_fifo_empty && rx_idle) begin
            rx_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_pd <= 1'b0;
         rx_pd <= 1'b0;
         line_reg <= 1'b1;
         call_reg <= 1'b0;
         call_change <= 1'b0;
      end else begin
         tx_pd <= tx_next;
         rx_pd <= rx_next;
         line_reg <= line_next;
         call_reg <= call_next;
         call_change <= change_next;
      end
   end

   sequence s_tx_idle;
      enable && thr_empty && tsr_empty && !thr_write;
   endsequence
   a_tx_sleep_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_tx_idle |=> tx_pd) else $error("tx did not sleep");
   a_tx_wake_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      thr_write |=> !tx_pd) else $error("tx did not wake");
   a_rx_wake_line: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (serial_in_line != $past(serial_in_line)) |=> !rx_pd)
      else $error("rx did not wake on line change");
   a_call_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(incoming_call_in) |=> call_change)
      else $error("call change lost");
endmodule : apd_serial_pd
`default_nettype wire

// ==== design/apd_par_pd.sv ====
// automatic powerdown of the ecp and epp parallel port logic
`default_nettype none
module apd_par_pd
   import apd_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // configuration
   input wire logic enable,
   input wire logic epp_cfg_en,
   input wire logic ecp_cfg_en,
   input wire logic [2:0] ecr_mode,
   // powerdown flags
   output logic epp_pd,
   output logic ecp_pd
);
   logic epp_next, ecp_next;

   // plain recompute each cycle, so any mode change takes effect at the next clock edge
   always_comb begin
      epp_next = 1'b0;
      ecp_next = 1'b0;
      if (enable) begin
         epp_next = !epp_cfg_en || (ecp_cfg_en && ecr_mode != APD_ECR_EPP);
         ecp_next = !ecp_cfg_en || ecr_mode == APD_ECR_SPP ||
                    ecr_mode == APD_ECR_BYTE || ecr_mode == APD_ECR_EPP;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         epp_pd <= 1'b0;
         ecp_pd <= 1'b0;
      end else begin
         epp_pd <= epp_next;
         ecp_pd <= ecp_next;
      end
   end

   a_epp_sleep: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (enable && !epp_cfg_en) |=> epp_pd)
      else $error("epp awake while not configured");
   a_ecp_sleep: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (enable && ecr_mode == APD_ECR_EPP) |=>
      ecp_pd && (epp_pd == !$past(epp_cfg_en)))
      else $error("ecp state wrong in epp mode");
   a_par_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !enable |=> !epp_pd && !ecp_pd)
      else $error("parallel asleep while disabled");
endmodule : apd_par_pd
`default_nettype wire

// ==== design/apd_top.sv ====
// floppy automatic powerdown, host register access and unit powerdown flags
`default_nettype none
module apd_top
   import apd_pkg::*;
#(
   parameter int PD_CYCLES = APD_PD_CYCLES
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // host register access
   input wire logic [2:0] host_addr,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   // automatic power configuration
   input wire logic [7:0] auto_power_cfg,
   // floppy core state
   input wire logic [7:0] core_status_a,
   input wire logic [7:0] core_status_b,
   input wire logic [7:0] core_digital_input,
   input wire logic [7:0] core_main_status,
   input wire logic [7:0] core_fifo_rdata,
   input wire logic core_int,
   input wire logic head_unload_expired,
   input wire apd_fdd_s core_fdd,
   // floppy core controls
   output logic [7:0] digital_output,
   output logic [7:0] data_rate_select,
   output logic [7:0] config_control,
   output logic fifo_rd_pulse,
   output logic fifo_wr_pulse,
   output logic [7:0] fifo_wdata,
   output logic fdc_access_active,
   // drive pins
   output apd_fdd_s fdd_out,
   output logic fdd_drive_oe,
   // serial ports
   input wire logic [1:0] thr_empty,
   input wire logic [1:0] tsr_empty,
   input wire logic [1:0] rx_fifo_empty,
   input wire logic [1:0] rx_idle,
   input wire logic [1:0] thr_write,
   input wire logic [1:0] serial_in_line,
   input wire logic [1:0] incoming_call_in,
   output logic [1:0] ser_tx_pd,
   output logic [1:0] ser_rx_pd,
   output logic [1:0] call_change,
   // parallel port
   input wire logic epp_cfg_en,
   input wire logic ecp_cfg_en,
   input wire logic [2:0] ecr_mode,
   output logic epp_pd,
   output logic ecp_pd,
   // floppy powerdown flag
   output logic fdc_pd
);
   localparam int CW = 17;

   // refused at elaboration: the timer counter is only CW bits wide
   if (PD_CYCLES < 1 || PD_CYCLES >= (1 << CW)) begin : g_bad_cycles
      $error("PD_CYCLES out of range");
   end

   // ****************************************
   // access decode
   // ****************************************
   function automatic logic wake_access(input logic [2:0] a, input logic rd,
                                        input logic wr, input logic [7:0] d);
      logic w;
      w = 1'b0;
      if (rd && a == APD_OFS_RATE_MAIN) begin
         w = 1'b1;
      end
      if ((rd || wr) && a == APD_OFS_FIFO) begin
         w = 1'b1;
      end
      if (wr && a == APD_OFS_DIG_OUT) begin
         w = (d[7:APD_DOR_MOTOR_LO] != 4'h0) || !d[APD_DOR_NRESET];
      end
      if (wr && a == APD_OFS_RATE_MAIN) begin
         w = d[APD_DSR_SWRESET];
      end
      return w;
   endfunction : wake_access

   // host strobes are decoded whatever the sleep state
   logic wake_now;
   logic fdc_en;
   assign wake_now = wake_access(host_addr, host_rd, host_wr, host_wdata);
   assign fdc_en = auto_power_cfg[APD_CFG_FDC];

   // ****************************************
   // floppy sleep state and timer
   // ****************************************
   apd_fdc_e state_reg, state_next;
   logic [CW-1:0] cnt_reg, cnt_next;
   logic fdc_idle;

   always_comb begin
      fdc_idle = core_fdd.spindle_on == 4'h0 &&
                 digital_output[7:APD_DOR_MOTOR_LO] == 4'h0 &&
                 core_main_status == APD_MSR_IDLE && !core_int &&
                 head_unload_expired;
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         APD_FDC_RUN: begin
            if (!fdc_en || wake_now) begin
               cnt_next = CW'(PD_CYCLES - 1);
            end else if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 1'b1;
            end else if (fdc_idle) begin
               state_next = APD_FDC_SLEEP;
            end
         end
         APD_FDC_SLEEP: begin
            cnt_next = CW'(PD_CYCLES - 1);
            // other accesses leave the state alone
            if (!fdc_en || wake_now) begin
               state_next = APD_FDC_RUN;
            end
         end
         default: begin
            state_next = APD_FDC_RUN;
            cnt_next = CW'(PD_CYCLES - 1);
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= APD_FDC_RUN;
         cnt_reg <= CW'(PD_CYCLES - 1);
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // ****************************************
   // host registers
   // ****************************************
   logic [7:0] dor_next, dsr_next, ccr_next, rdata_next, fwd_next;
   logic frd_next, fwr_next, act_next;

   always_comb begin
      dor_next = digital_output;
      dsr_next = data_rate_select;
      ccr_next = config_control;
      fwd_next = fifo_wdata;
      frd_next = host_rd && host_addr == APD_OFS_FIFO;
      fwr_next = host_wr && host_addr == APD_OFS_FIFO;
      // a short access window; the sleep flag itself is not touched
      act_next = (host_rd || host_wr) && state_reg == APD_FDC_SLEEP;
      if (fwr_next) begin
         fwd_next = host_wdata;
      end
      if (host_wr) begin
         unique case (host_addr)
            APD_OFS_DIG_OUT: dor_next = host_wdata;
            APD_OFS_RATE_MAIN: dsr_next = host_wdata;
            APD_OFS_DIN_CFG: ccr_next = host_wdata;
            default: ;
         endcase
      end
      rdata_next = host_rdata;
      if (host_rd) begin
         unique case (host_addr)
            APD_OFS_STATUS_A: rdata_next = core_status_a;
            APD_OFS_STATUS_B: rdata_next = core_status_b;
            APD_OFS_DIG_OUT: rdata_next = digital_output;
            APD_OFS_RATE_MAIN: rdata_next = core_main_status;
            APD_OFS_FIFO: rdata_next = core_fifo_rdata;
            APD_OFS_DIN_CFG: rdata_next = core_digital_input;
            default: rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         digital_output <= APD_DOR_RST;
         data_rate_select <= APD_DSR_RST;
         config_control <= APD_CCR_RST;
         host_rdata <= 8'h00;
         fifo_wdata <= 8'h00;
         fifo_rd_pulse <= 1'b0;
         fifo_wr_pulse <= 1'b0;
         fdc_access_active <= 1'b0;
      end else begin
         digital_output <= dor_next;
         data_rate_select <= dsr_next;
         config_control <= ccr_next;
         host_rdata <= rdata_next;
         fifo_wdata <= fwd_next;
         fifo_rd_pulse <= frd_next;
         fifo_wr_pulse <= fwr_next;
         fdc_access_active <= act_next;
      end
   end

   // ****************************************
   // drive pins
   // ****************************************
   apd_fdd_s fdd_next;
   logic sleep_next;

   always_comb begin
      sleep_next = state_next == APD_FDC_SLEEP;
      // step, direction, head, density, rate, motor, select and write all keep running
      fdd_next = core_fdd;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fdd_out <= '0;
         fdd_drive_oe <= 1'b0;
         fdc_pd <= 1'b0;
      end else begin
         fdd_out <= fdd_next;
         fdd_drive_oe <= !sleep_next;
         fdc_pd <= sleep_next;
      end
   end

   // ****************************************
   // serial and parallel units
   // ****************************************
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_ser
         apd_serial_pd u_ser (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .enable(auto_power_cfg[APD_CFG_SER0 + gi]),
            .thr_empty(thr_empty[gi]),
            .tsr_empty(tsr_empty[gi]),
            .rx_fifo_empty(rx_fifo_empty[gi]),
            .rx_idle(rx_idle[gi]),
            .thr_write(thr_write[gi]),
            .serial_in_line(serial_in_line[gi]),
            .incoming_call_in(incoming_call_in[gi]),
            .tx_pd(ser_tx_pd[gi]),
            .rx_pd(ser_rx_pd[gi]),
            .call_change(call_change[gi])
         );
      end
   endgenerate

   apd_par_pd u_par (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .enable(auto_power_cfg[APD_CFG_PAR]),
      .epp_cfg_en(epp_cfg_en),
      .ecp_cfg_en(ecp_cfg_en),
      .ecr_mode(ecr_mode),
      .epp_pd(epp_pd),
      .ecp_pd(ecp_pd)
   );

   // ****************************************
   // checks
   // ****************************************
   sequence s_sleep_quiet;
      fdc_pd && fdc_en && !wake_now;
   endsequence
   a_msr_read_wake: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (fdc_pd && host_rd && host_addr == APD_OFS_RATE_MAIN) |=> !fdc_pd)
      else $error("main status read did not wake");
   a_quiet_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_sleep_quiet |=> fdc_pd) else $error("woke without cause");
   a_dor_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (s_sleep_quiet and (host_wr && host_addr == APD_OFS_DIG_OUT))
      |=> digital_output == $past(host_wdata))
      else $error("sleeping write lost");
   a_entry_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(fdc_pd) |-> $past(fdc_idle) && $past(cnt_reg) == '0 &&
      !fdd_drive_oe) else $error("slept while busy");
   a_wake_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(fdc_pd) |-> cnt_reg == CW'(PD_CYCLES - 1) && fdd_drive_oe)
      else $error("timer not restarted");
   a_disable_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !fdc_en |=> !fdc_pd) else $error("asleep while disabled");
endmodule : apd_top
`default_nettype wire

// ==== test/apd_host_model.sv ====
// host processor model driving the floppy register port
`default_nettype none
module apd_host_model
(
   // clock
   input wire logic clk_sys,
   // register port
   output logic [2:0] host_addr,
   output logic host_rd,
   output logic host_wr,
   output logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      host_addr = 3'h6;
      host_rd = 1'h0;
      host_wr = 1'h0;
      host_wdata = 8'h00;
   end
   // ****************************************
   // one access, strobe held for one edge
   // ****************************************
   // address and data are inverted on release so a stale bus never
   // looks like a held one
   task automatic access(input logic wr, input logic [2:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_sys);
      host_addr <= a;
      host_wdata <= d;
      host_rd <= !wr;
      host_wr <= wr;
      @(posedge clk_sys);
      host_rd <= 1'h0;
      host_wr <= 1'h0;
      host_addr <= ~a;
      host_wdata <= ~d;
      #1 q = host_rdata;
   endtask : access
endmodule : apd_host_model
`default_nettype wire

// ==== test/apd_top_tb.sv ====
// self-checking bench for the automatic powerdown control block
`default_nettype none
module apd_top_tb
   import apd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PD = 20;
   logic clk_sys, rst_n, host_rd, host_wr, core_int, head_unload_expired;
   logic [2:0] host_addr, ecr_mode;
   logic [7:0] host_wdata, host_rdata, auto_power_cfg, q, core_msr;
   logic [7:0] digital_output, data_rate_select, config_control, fifo_wdata;
   logic fifo_rd_pulse, fifo_wr_pulse, fdc_access_active, fdd_drive_oe;
   logic fdc_pd, epp_cfg_en, ecp_cfg_en, epp_pd, ecp_pd, seen;
   apd_fdd_s core_fdd, fdd_out;
   logic [1:0] thr_empty, tsr_empty, rx_fifo_empty, rx_idle, thr_write;
   logic [1:0] serial_in_line, incoming_call_in, ser_tx_pd, ser_rx_pd;
   logic [1:0] call_change;
   int miscompares = 0;
   int num_checks = 0;
   logic wk_wr [6] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1};
   logic [2:0] wk_a [6] = '{3'h4, 3'h5, 3'h5, 3'h2, 3'h2, 3'h4};
   logic [7:0] wk_d [6] = '{8'h00, 8'h00, 8'h33, 8'h14, 8'h00, 8'h80};
   // {epp cfg, ecp cfg, mode, epp asleep, ecp asleep}
   logic [6:0] pt [6] = '{7'h33, 7'h71, 7'h63, 7'h67, 7'h2e, 7'h4d};

   apd_top #(.PD_CYCLES(PD)) uut (
      .clk_sys(clk_sys), .rst_n(rst_n), .host_addr(host_addr),
      .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .auto_power_cfg(auto_power_cfg),
      .core_status_a(8'ha5), .core_status_b(8'h3c),
      .core_digital_input(8'h81), .core_main_status(core_msr),
      .core_fifo_rdata(8'h5e), .core_int(core_int),
      .head_unload_expired(head_unload_expired), .core_fdd(core_fdd),
      .digital_output(digital_output), .data_rate_select(data_rate_select),
      .config_control(config_control), .fifo_rd_pulse(fifo_rd_pulse),
      .fifo_wr_pulse(fifo_wr_pulse), .fifo_wdata(fifo_wdata),
      .fdc_access_active(fdc_access_active), .fdd_out(fdd_out),
      .fdd_drive_oe(fdd_drive_oe), .thr_empty(thr_empty),
      .tsr_empty(tsr_empty), .rx_fifo_empty(rx_fifo_empty),
      .rx_idle(rx_idle), .thr_write(thr_write),
      .serial_in_line(serial_in_line), .incoming_call_in(incoming_call_in),
      .ser_tx_pd(ser_tx_pd), .ser_rx_pd(ser_rx_pd),
      .call_change(call_change), .epp_cfg_en(epp_cfg_en),
      .ecp_cfg_en(ecp_cfg_en), .ecr_mode(ecr_mode), .epp_pd(epp_pd),
      .ecp_pd(ecp_pd), .fdc_pd(fdc_pd));

   apd_host_model host (
      .clk_sys(clk_sys), .host_addr(host_addr), .host_rd(host_rd),
      .host_wr(host_wr), .host_wdata(host_wdata), .host_rdata(host_rdata));

   initial begin
      clk_sys = 1'h0;
      forever #50 clk_sys = ~clk_sys;
   end
   // ****************************************
   // common tasks
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_cyc

   // timer reload gives sleep PD cycles later; margin both sides
   task automatic go_sleep();
      wait_cyc(PD - 4);
      chk(fdc_pd, 1'h0);
      wait_cyc(7);
      chk(fdc_pd, 1'h1);
      chk(fdd_drive_oe, 1'h0);
      chk(fdd_out, core_fdd);
   endtask : go_sleep

   task automatic final_report();
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      wait_cyc(1);
      chk(digital_output, 8'h04);
      chk(data_rate_select, 8'h02);
      chk(config_control, 8'h02);
      chk({fdc_pd, ser_tx_pd, ser_rx_pd}, 5'h00);
      go_sleep();
   endtask : t_reset

   task automatic t_asleep_access();
      host.access(1'h0, APD_OFS_STATUS_A, 8'h00, q);
      chk({q, 7'h00, fdc_access_active}, 16'ha501);
      host.access(1'h0, APD_OFS_STATUS_B, 8'h00, q);
      chk({q, 7'h00, fdc_pd}, 16'h3c01);
      host.access(1'h0, APD_OFS_DIN_CFG, 8'h00, q);
      chk({q, 7'h00, fdc_pd}, 16'h8101);
      host.access(1'h1, APD_OFS_DIN_CFG, 8'h03, q);
      chk({config_control, 7'h00, fdc_pd}, 16'h0301);
      host.access(1'h1, APD_OFS_RATE_MAIN, 8'h01, q);
      chk({data_rate_select, 7'h00, fdc_pd}, 16'h0101);
      host.access(1'h1, APD_OFS_DIG_OUT, 8'h04, q);
      host.access(1'h0, APD_OFS_DIG_OUT, 8'h00, q);
      chk({q, 7'h00, fdc_pd}, 16'h0401);
      chk(fdd_drive_oe, 1'h0);
   endtask : t_asleep_access

   task automatic t_wake();
      for (int i = 0; i < 6; i++) begin
         host.access(wk_wr[i], wk_a[i], wk_d[i], q);
         chk({fdc_pd, fdd_drive_oe}, 2'h1);
         chk(fifo_wdata, (i > 1) ? 8'h33 : 8'h00);
         chk({fifo_rd_pulse, fifo_wr_pulse}, (wk_a[i] != 3'h5) ? 2'h0 :
            (wk_wr[i] ? 2'h1 : 2'h2));
         if (!wk_wr[i]) begin
            chk(q, (wk_a[i] == 3'h4) ? 8'h80 : 8'h5e);
         end
         host.access(1'h1, APD_OFS_DIG_OUT, 8'h04, q);
         go_sleep();
      end
   endtask : t_wake

   task automatic t_hold_awake();
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_sys);
         core_int <= (k == 0);
         head_unload_expired <= (k != 1);
         core_msr <= (k == 2) ? 8'h90 : APD_MSR_IDLE;
         host.access(1'h0, APD_OFS_RATE_MAIN, 8'h00, q);
         wait_cyc(PD + 5);
         chk(fdc_pd, 1'h0);
         @(posedge clk_sys);
         core_int <= 1'h0;
         head_unload_expired <= 1'h1;
         core_msr <= APD_MSR_IDLE;
         wait_cyc(4);
         chk(fdc_pd, 1'h1);
      end
      @(posedge clk_sys);
      auto_power_cfg <= 8'h38;
      wait_cyc(3);
      chk(fdc_pd, 1'h0);
      wait_cyc(PD + 5);
      chk(fdc_pd, 1'h0);
   endtask : t_hold_awake

   task automatic t_serial(input int p);
      @(posedge clk_sys);
      thr_empty[p] <= 1'h1;
      rx_fifo_empty[p] <= 1'h1;
      wait_cyc(3);
      chk({ser_tx_pd[p], ser_rx_pd[p]}, 2'h0);
      @(posedge clk_sys);
      tsr_empty[p] <= 1'h1;
      rx_idle[p] <= 1'h1;
      wait_cyc(3);
      chk({ser_tx_pd[p], ser_rx_pd[p]}, 2'h3);
      @(posedge clk_sys);
      incoming_call_in[p] <= ~incoming_call_in[p];
      seen = 1'h0;
      repeat (4) begin
         wait_cyc(1);
         seen = seen | call_change[p];
      end
      chk(seen, 1'h1);
      @(posedge clk_sys);
      thr_write[p] <= 1'h1;
      thr_empty[p] <= 1'h0;
      @(posedge clk_sys);
      thr_write[p] <= 1'h0;
      serial_in_line[p] <= ~serial_in_line[p];
      rx_idle[p] <= 1'h0;
      wait_cyc(3);
      chk({ser_tx_pd[p], ser_rx_pd[p]}, 2'h0);
      @(posedge clk_sys);
      thr_empty[p] <= 1'h1;
      rx_idle[p] <= 1'h1;
      auto_power_cfg[4 + p] <= 1'h0;
      wait_cyc(4);
      chk({ser_tx_pd[p], ser_rx_pd[p]}, 2'h0);
   endtask : t_serial

   task automatic t_parallel();
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         {epp_cfg_en, ecp_cfg_en, ecr_mode} <= pt[i][6:2];
         wait_cyc(2);
         chk({epp_pd, ecp_pd}, pt[i][1:0]);
      end
      @(posedge clk_sys);
      auto_power_cfg[3] <= 1'h0;
      wait_cyc(2);
      chk({epp_pd, ecp_pd}, 2'h0);
   endtask : t_parallel
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      rst_n = 1'h0;
      auto_power_cfg = 8'h39;
      core_int = 1'h0;
      core_msr = 8'h80;
      head_unload_expired = 1'h1;
      core_fdd = '0;
      core_fdd.step = 1'h1;
      core_fdd.head_pick = 1'h1;
      core_fdd.rate_code_out = 2'h2;
      {thr_empty, tsr_empty, rx_fifo_empty, rx_idle} = 8'h00;
      // serial lines idle high, matching the receiver's reset sample
      {thr_write, serial_in_line, incoming_call_in} = 6'h0c;
      {epp_cfg_en, ecp_cfg_en, ecr_mode} = 5'h00;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'h1;
      t_reset();
      t_asleep_access();
      t_wake();
      t_hold_awake();
      t_serial(0);
      t_serial(1);
      t_parallel();
      final_report();
   end

   initial begin
      repeat (5000) @(posedge clk_sys);
      miscompares++;
      final_report();
   end
endmodule : apd_top_tb
`default_nettype wire
